// [clk_standby_pkg.sv]
// constants and types for the system clock and standby control block
// Function
// - one fundamental clock from the high-frequency oscillator feeds everything.
// - timing generator makes time base, watchdog and timer counter source clocks.
// - three-stage prescaler, twenty-one-stage divider chain, machine cycle counter.
// - reset clears all prescaler and divider stages to zero.
// - single clock mode: machine cycle lasts four fundamental clock periods.
// - only the high-frequency oscillator is used in single clock mode.
// - standby control starts/stops oscillator from control reg two; main clock select is fixed high.
// - after reset the device is in NORMAL mode.
// - IDLE stops CPU and watchdog clocks; peripherals keep running.
// - IDLE entered only by software writing the idle request.
// - peripheral or external interrupt request returns IDLE to NORMAL.
// - wake with interrupt enable at 1: service the interrupt first.
// - wake with interrupt enable at 0: resume at next instruction, no service.
package clk_standby_pkg;
    localparam int PRESCALE_STAGES = 3;
    localparam int DIVIDER_STAGES = 21;
    localparam int MCYC_PERIODS = 4;
    localparam logic [1:0] MCYC_LAST = 2'h3;
    localparam logic [PRESCALE_STAGES-1:0] PRESCALE_RESET = 3'h0;
    localparam logic [DIVIDER_STAGES-1:0] DIVIDER_RESET = 21'h000000;
    localparam logic [1:0] MCYC_RESET = 2'h0;
    // control register two layout
    localparam int SCR2_OSC_EN_BIT = 7;
    localparam int SCR2_IDLE_BIT = 4;
    localparam logic [7:0] SCR2_RESET = 8'h80;
    localparam logic [7:0] SCR2_WRITE_MASK = 8'h90;
    // divider taps for the derived source clocks
    localparam int TBT_TAP = 20;
    localparam int WDT_TAP = 12;
    localparam int TC_TAP = 4;

    typedef enum logic [0:0]
    {
        MODE_NORMAL = 1'b0,
        MODE_IDLE = 1'b1
    } standby_mode_t;
endpackage

// [timing_generator.sv]
// prescaler, divider chain and machine cycle counter
`timescale 1ns/1ps
module timing_generator
#(
    parameter int PRE_W = 3,
    parameter int DIV_W = 21
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic run,
    input wire logic cpu_run,
    output logic [PRE_W-1:0] prescale_q,
    output logic [DIV_W-1:0] divider_q,
    output logic mcyc_strobe
);
    import clk_standby_pkg::*;

    logic [1:0] mcyc_r;
    logic pre_wrap;

    assign pre_wrap = &prescale_q;

    // ------------------------------------------------------------
    // prescaler feeding divider
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rstn)
            prescale_q <= PRESCALE_RESET;
        else if (run)
            prescale_q <= prescale_q + 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            divider_q <= DIVIDER_RESET;
        else if (run && pre_wrap)
            divider_q <= divider_q + 1'b1;
    end

    // ------------------------------------------------------------
    // machine cycle counter
    // ------------------------------------------------------------
    // held while the core sleeps so a cycle resumes from its held count on wake
    always_ff @(posedge clk)
    begin
        if (!rstn)
            mcyc_r <= MCYC_RESET;
        else if (run && cpu_run)
            mcyc_r <= mcyc_r + 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            mcyc_strobe <= 1'b0;
        else
            mcyc_strobe <= run && cpu_run && (mcyc_r == MCYC_LAST);
    end
endmodule

// [system_clock_standby_control.sv]
// system clock and standby controller top
`timescale 1ns/1ps
module system_clock_standby_control
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic scr2_wr,
    input wire logic [7:0] scr2_wdata,
    output logic [7:0] scr2_rdata,
    input wire logic periph_irq,
    input wire logic ext_irq_pin,
    input wire logic master_interrupt_enable_flag,
    output logic osc_enable,
    output logic main_clk_sel_high,
    output logic cpu_clk_en,
    output logic wdt_clk_en,
    output logic periph_clk_en,
    output logic mcyc_strobe,
    output logic tbt_src,
    output logic wdt_src,
    output logic tc_src,
    output logic wake_pulse,
    output logic wake_service_irq,
    output logic wake_resume_next,
    output clk_standby_pkg::standby_mode_t mode
);
    import clk_standby_pkg::*;

    logic [7:0] scr2_r;
    logic ext_s1_r;
    logic ext_s2_r;
    logic wake_req;
    logic [PRESCALE_STAGES-1:0] pre_q;
    logic [DIVIDER_STAGES-1:0] div_q;
    standby_mode_t mode_nxt;

    // ------------------------------------------------------------
    // external interrupt synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
        end
        else
        begin
            ext_s1_r <= ext_irq_pin;
            ext_s2_r <= ext_s1_r;
        end
    end

    assign wake_req = periph_irq | ext_s2_r;

    // ------------------------------------------------------------
    // control register two
    // ------------------------------------------------------------
    // wake beats a same-cycle idle write so no interrupt is lost
    always_ff @(posedge clk)
    begin
        if (!rstn)
            scr2_r <= SCR2_RESET;
        else if (mode == MODE_IDLE && wake_req)
            scr2_r[SCR2_IDLE_BIT] <= 1'b0;
        else if (scr2_wr)
            scr2_r <= (scr2_wdata & SCR2_WRITE_MASK) | (scr2_r & ~SCR2_WRITE_MASK);
    end

    assign scr2_rdata = scr2_r;

    // ------------------------------------------------------------
    // standby state machine
    // ------------------------------------------------------------
    always_comb
    begin
        mode_nxt = mode;
        case (mode)
            MODE_NORMAL:
            begin
                if (scr2_wr && scr2_wdata[SCR2_IDLE_BIT])
                    mode_nxt = MODE_IDLE;
            end
            MODE_IDLE:
            begin
                if (wake_req)
                    mode_nxt = MODE_NORMAL;
            end
            default:
                mode_nxt = MODE_NORMAL;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            mode <= MODE_NORMAL;
        else
            mode <= mode_nxt;
    end

    // ------------------------------------------------------------
    // wake outcome toward the core
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            wake_pulse <= 1'b0;
            wake_service_irq <= 1'b0;
            wake_resume_next <= 1'b0;
        end
        else
        begin
            wake_pulse <= mode == MODE_IDLE && wake_req;
            wake_service_irq <= mode == MODE_IDLE && wake_req && master_interrupt_enable_flag;
            wake_resume_next <= mode == MODE_IDLE && wake_req && !master_interrupt_enable_flag;
        end
    end

    // ------------------------------------------------------------
    // clock gating
    // ------------------------------------------------------------
    // only the high-frequency source exists, so select is fixed high
    assign osc_enable = scr2_r[SCR2_OSC_EN_BIT];
    assign main_clk_sel_high = 1'b1;
    assign cpu_clk_en = osc_enable && mode == MODE_NORMAL;
    assign wdt_clk_en = osc_enable && mode == MODE_NORMAL;
    assign periph_clk_en = osc_enable;

    // ------------------------------------------------------------
    // timing generator
    // ------------------------------------------------------------
    timing_generator
    #(
        .PRE_W(PRESCALE_STAGES),
        .DIV_W(DIVIDER_STAGES)
    )
    u_tg
    (
        .clk(clk),
        .rstn(rstn),
        .run(osc_enable),
        .cpu_run(cpu_clk_en),
        .prescale_q(pre_q),
        .divider_q(div_q),
        .mcyc_strobe(mcyc_strobe)
    );

    // tbt_src and tc_src come straight from registered divider stages; wdt_src is a stage ANDed with wdt_clk_en
    assign tbt_src = div_q[TBT_TAP];
    assign wdt_src = div_q[WDT_TAP] & wdt_clk_en;
    assign tc_src = div_q[TC_TAP];
endmodule

// [system_clock_standby_control_properties.sv]
// checker of the clock and standby controller
`timescale 1ns/1ps
module scsc_properties
import clk_standby_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic scr2_wr,
    input wire logic [7:0] scr2_wdata,
    input wire logic [7:0] scr2_rdata,
    input wire logic periph_irq,
    input wire logic osc_enable,
    input wire logic main_clk_sel_high,
    input wire logic cpu_clk_en,
    input wire logic wdt_clk_en,
    input wire logic periph_clk_en,
    input wire logic mcyc_strobe,
    input wire logic wake_pulse,
    input wire logic wake_service_irq,
    input wire logic wake_resume_next,
    input wire standby_mode_t mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_idle_req;
        scr2_wr && scr2_wdata[7] && scr2_wdata[4] && mode == MODE_NORMAL && !periph_irq;
    endsequence
    sequence s_wake_req;
        mode == MODE_IDLE && periph_irq;
    endsequence
    chk_idle_entry: assert property (s_idle_req |=> mode == MODE_IDLE)
        else $error("idle not entered");
    chk_idle_gating: assert property (mode == MODE_IDLE |-> !cpu_clk_en && !wdt_clk_en && periph_clk_en)
        else $error("idle gating wrong");
    chk_normal_run: assert property (mode == MODE_NORMAL && osc_enable |-> cpu_clk_en && wdt_clk_en)
        else $error("normal clocks off");
    chk_wake_step: assert property (s_wake_req |=> mode == MODE_NORMAL && wake_pulse && !scr2_rdata[4])
        else $error("wake step wrong");
    chk_wake_kind: assert property (wake_pulse |-> wake_service_irq ^ wake_resume_next)
        else $error("wake kind wrong");
    chk_wake_cause: assert property (wake_pulse |-> $past(mode) == MODE_IDLE)
        else $error("wake without idle");
    chk_mcyc_gap: assert property (mcyc_strobe |=> !mcyc_strobe [*3])
        else $error("machine cycle short");
    chk_clock_source: assert property (main_clk_sel_high && periph_clk_en == osc_enable)
        else $error("clock source wrong");
    chk_idle_core_stop: assert property (mode == MODE_IDLE && $past(mode) == MODE_IDLE |-> !mcyc_strobe)
        else $error("core paced in idle");
endmodule
bind system_clock_standby_control scsc_properties u_chk (.clk, .rstn, .scr2_wr, .scr2_wdata, .scr2_rdata,
    .periph_irq, .osc_enable, .main_clk_sel_high, .cpu_clk_en, .wdt_clk_en, .periph_clk_en, .mcyc_strobe,
    .wake_pulse, .wake_service_irq, .wake_resume_next, .mode);

// [irq_source.sv]
// interrupt sources standing beside the controller
`timescale 1ns/1ps
module irq_source
(
    input wire logic clk,
    input wire logic go,
    input wire logic use_ext,
    output logic periph_irq,
    output logic ext_irq_pin
);
    int hold = 0;
    // level held four cycles, long enough for the pin synchroniser
    always @(negedge clk)
        hold <= go ? 4 : (hold > 0 ? hold - 1 : 0);
    assign periph_irq = hold > 0 && !use_ext;
    assign ext_irq_pin = hold > 0 && use_ext;
endmodule

// [system_clock_standby_control_tb.sv]
// self-checking bench of the clock and standby controller
`timescale 1ns/1ps
`define CHK(s, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; $display("MISMATCH %s exp %h got %h", s, e, g); end end
module system_clock_standby_control_tb;
    import clk_standby_pkg::*;
    logic clk = 0, rstn = 0, scr2_wr = 0, master_interrupt_enable_flag = 0, go = 0, use_ext = 0;
    logic [7:0] scr2_wdata = 8'h00, scr2_rdata;
    logic periph_irq, ext_irq_pin, osc_enable, main_clk_sel_high, cpu_clk_en, wdt_clk_en, periph_clk_en;
    logic mcyc_strobe, wake_pulse, wake_service_irq, wake_resume_next, tbt_src, wdt_src, tc_src;
    standby_mode_t mode;
    int err_total = 0, num_checks = 0, n;
    typedef struct {logic ext; logic flag; int lat;} row_t;
    row_t rows [4] = '{'{1'b0, 1'b1, 2}, '{1'b0, 1'b0, 2}, '{1'b1, 1'b1, 4}, '{1'b1, 1'b0, 4}};
    always #4 clk = ~clk;
    system_clock_standby_control u_dut (.clk, .rstn, .scr2_wr, .scr2_wdata, .scr2_rdata, .periph_irq, .ext_irq_pin,
        .master_interrupt_enable_flag, .osc_enable, .main_clk_sel_high, .cpu_clk_en, .wdt_clk_en, .periph_clk_en,
        .mcyc_strobe, .tbt_src, .wdt_src, .tc_src, .wake_pulse, .wake_service_irq, .wake_resume_next, .mode);
    irq_source u_src (.clk, .go, .use_ext, .periph_irq, .ext_irq_pin);
    task automatic write2(input logic [7:0] d);
        @(negedge clk);
        scr2_wr = 1;
        scr2_wdata = d;
        @(negedge clk);
        scr2_wr = 0;
    endtask
    task automatic gap(output int c);
        c = 0;
        do
        begin
            @(negedge clk);
            c++;
        end
        while (!mcyc_strobe && c < 9);
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        #20000;
        err_total++;
        print_verdict;
    end
    initial
    begin
        repeat (8) @(negedge clk);
        rstn = 1;
        `CHK("mode", MODE_NORMAL, mode)
        `CHK("rdata", 8'h80, scr2_rdata)
        gap(n);
        gap(n);
        `CHK("mcyc", MCYC_PERIODS, n)
        $display("reset and cycle case done");
        foreach (rows[i])
        begin
            master_interrupt_enable_flag = rows[i].flag;
            use_ext = rows[i].ext;
            write2(8'h90);
            `CHK("idle", MODE_IDLE, mode)
            `CHK("cpu_en", 1'b0, cpu_clk_en)
            `CHK("per_en", 1'b1, periph_clk_en)
            go <= 1;
            n = 0;
            while (!wake_pulse && n < 20)
            begin
                @(negedge clk);
                go <= 0;
                n++;
            end
            `CHK("latency", rows[i].lat, n)
            `CHK("mode", MODE_NORMAL, mode)
            `CHK("rdata", 8'h80, scr2_rdata)
            `CHK("svc", rows[i].flag, wake_service_irq)
            `CHK("resume", ~rows[i].flag, wake_resume_next)
            repeat (6) @(negedge clk);
            $display("wake case %0d done", i);
        end
        // write landing on the wake edge must lose
        use_ext = 0;
        write2(8'h90);
        go <= 1;
        @(negedge clk);
        go <= 0;
        scr2_wr = 1;
        scr2_wdata = 8'h10;
        @(negedge clk);
        scr2_wr = 0;
        `CHK("mode", MODE_NORMAL, mode)
        `CHK("rdata", 8'h80, scr2_rdata)
        repeat (6) @(negedge clk);
        write2(8'h00);
        `CHK("osc", 1'b0, periph_clk_en)
        @(negedge clk);
        gap(n);
        `CHK("mcyc_off", 9, n)
        write2(8'h80);
        `CHK("no_idle", MODE_NORMAL, mode)
        `CHK("cpu_en", 1'b1, cpu_clk_en)
        write2(8'h90);
        rstn = 0;
        repeat (8) @(negedge clk);
        rstn = 1;
        `CHK("mode", MODE_NORMAL, mode)
        `CHK("rdata", 8'h80, scr2_rdata)
        `CHK("tbt_rst", 1'b0, tbt_src)
        `CHK("wdt_rst", 1'b0, wdt_src)
        `CHK("tc_rst", 1'b0, tc_src)
        n = 0;
        while (!tc_src && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        `CHK("tc_rise", 1 << (TC_TAP + PRESCALE_STAGES), n)
        $display("edge cases done");
        print_verdict;
    end
endmodule
